// >>> verilog/dacc_defs.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef DACC_DEFS_SVH
`define DACC_DEFS_SVH
`define DACC_OFS_DATA_CH0 16'hfff8
`define DACC_OFS_DATA_CH1 16'hfff9
`define DACC_OFS_CONTROL 16'hfffa
`define DACC_DATA_RESET 8'h00
`define DACC_CONTROL_RESET 8'h1f
`define DACC_RSVD_MASK 8'h1f
`define DACC_BIT_OE1 7
`define DACC_BIT_OE0 6
`define DACC_BIT_JOINT 5
`define DACC_CONV_TIME_NS 10000
`define DACC_CLK_PERIOD_NS 20
`define DACC_CONV_CYCLES (`DACC_CONV_TIME_NS / `DACC_CLK_PERIOD_NS)
`endif

// >>> verilog/dacc_pkg.sv
// Types shared by the converter control block
`default_nettype none
package dacc_pkg;
  typedef struct packed {
    logic [7:0] code;
    logic convert_en;
    logic drive_en;
    logic settled;
  } dacc_chan_t;
  typedef struct packed {
    logic out_enable_ch1;
    logic out_enable_ch0;
    logic joint_convert_enable;
    logic [4:0] reserved;
  } dacc_ctrl_t;
endpackage : dacc_pkg
`default_nettype wire

// >>> verilog/dacc_control.sv
// Two-channel 8-bit converter control logic with register port
//
// The plain strobed port was chosen for this implementation.
`include "dacc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dacc_control
  import dacc_pkg::*;
#(
  parameter int CONV_CYCLES = `DACC_CONV_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Standby entry
  input wire logic standby,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Analog macro, channel 0
  output logic [7:0] code_ch0,
  output logic convert_en_ch0,
  output logic analog_out_pin_0_oe,
  output logic settled_ch0,
  // Analog macro, channel 1
  output logic [7:0] code_ch1,
  output logic convert_en_ch1,
  output logic analog_out_pin_1_oe,
  output logic settled_ch1,
  // Analog power
  output logic analog_power_en
);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  function automatic logic [1:0] dacc_sel(input logic [15:0] a);
    dacc_sel = 2'h3;
    if (a == `DACC_OFS_DATA_CH0)
      dacc_sel = 2'h0;
    else if (a == `DACC_OFS_DATA_CH1)
      dacc_sel = 2'h1;
    else if (a == `DACC_OFS_CONTROL)
      dacc_sel = 2'h2;
  endfunction : dacc_sel

  logic [7:0] conv_data [2];
  dacc_ctrl_t converter_control;
  logic [1:0] sel;
  logic [1:0] data_written;
  logic [1:0] chan_oe;
  logic [1:0] chan_conv;
  logic [7:0] next_rdata;

  assign sel = dacc_sel(addr);
  assign chan_oe[0] = converter_control.out_enable_ch0;
  assign chan_oe[1] = converter_control.out_enable_ch1;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      converter_control <= `DACC_CONTROL_RESET;
    else if (clk_en)
    begin
      if (standby)
        converter_control <= `DACC_CONTROL_RESET;
      else if (wr && sel == 2'h2)
        converter_control <= (wdata & ~`DACC_RSVD_MASK) | `DACC_RSVD_MASK;
    end
  end

  // Joint bit couples conversion only; drive never couples
  always_comb
  begin
    if (converter_control.joint_convert_enable)
      chan_conv = {2{|chan_oe}};
    else
      chan_conv = chan_oe;
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_chan
      logic [$clog2(CONV_CYCLES+1)-1:0] settle_cnt;
      dacc_chan_t chan;

      assign data_written[g] = wr && sel == 2'(g);

      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          conv_data[g] <= `DACC_DATA_RESET;
        else if (clk_en)
        begin
          if (standby)
            conv_data[g] <= `DACC_DATA_RESET;
          else if (data_written[g])
            conv_data[g] <= wdata;
        end
      end

      // Counter restarts on each new code so settled never shows a stale level
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          settle_cnt <= '0;
        else if (clk_en)
        begin
          if (!chan_conv[g] || data_written[g] || standby)
            settle_cnt <= '0;
          else if (settle_cnt != CONV_CYCLES[$clog2(CONV_CYCLES+1)-1:0])
            settle_cnt <= settle_cnt + 1'b1;
        end
      end

      // Macro outputs registered; level is supply * code / 256 inside the macro
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          chan <= '0;
        else if (clk_en)
        begin
          chan.code <= conv_data[g];
          chan.convert_en <= chan_conv[g];
          chan.drive_en <= chan_oe[g];
          // A write or standby in this cycle restarts the count, so settled drops at once
          chan.settled <= chan_oe[g] && chan_conv[g] && !data_written[g] && !standby &&
                          settle_cnt == CONV_CYCLES[$clog2(CONV_CYCLES+1)-1:0];
        end
      end
    end
  endgenerate

  assign code_ch0 = gen_chan[0].chan.code;
  assign convert_en_ch0 = gen_chan[0].chan.convert_en;
  assign analog_out_pin_0_oe = gen_chan[0].chan.drive_en;
  assign settled_ch0 = gen_chan[0].chan.settled;
  assign code_ch1 = gen_chan[1].chan.code;
  assign convert_en_ch1 = gen_chan[1].chan.convert_en;
  assign analog_out_pin_1_oe = gen_chan[1].chan.drive_en;
  assign settled_ch1 = gen_chan[1].chan.settled;

  // ----------------------------------------
  // Analog power
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      analog_power_en <= 1'b0;
    else if (clk_en)
      analog_power_en <= converter_control.joint_convert_enable | (|chan_conv);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (sel)
      2'h0: next_rdata = conv_data[0];
      2'h1: next_rdata = conv_data[1];
      2'h2: next_rdata = converter_control;
      default: next_rdata = 8'h00;
    endcase
  end

  // Unmapped addresses read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (clk_en && rd)
      rdata <= next_rdata;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ctrl_low_ones: assert property (@(posedge clk) disable iff (rst)
    converter_control[4:0] == 5'h1f)
    else $error("control low bits not all one");
  a_data_readback: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h0 && !standby ##1 clk_en && rd && sel == 2'h0 && !wr
    |=> rdata == $past(wdata, 2))
    else $error("data readback mismatch");
  a_standby_clear: assert property (@(posedge clk) disable iff (rst)
    clk_en && standby |=> conv_data[0] == 8'h00 && conv_data[1] == 8'h00)
    else $error("data not cleared by standby");
  a_standby_ctrl: assert property (@(posedge clk) disable iff (rst)
    clk_en && standby |=> converter_control == 8'h1f)
    else $error("control not reset by standby");
  a_drive_own_bit: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> analog_out_pin_0_oe == $past(converter_control.out_enable_ch0) &&
               analog_out_pin_1_oe == $past(converter_control.out_enable_ch1))
    else $error("drive does not follow own enable");
  a_joint_convert: assert property (@(posedge clk) disable iff (rst)
    clk_en && converter_control.joint_convert_enable && (|chan_oe)
    |=> convert_en_ch0 && convert_en_ch1)
    else $error("joint conversion not applied");
  a_power_joint: assert property (@(posedge clk) disable iff (rst)
    clk_en && converter_control.joint_convert_enable |=> analog_power_en)
    else $error("analog power dropped under joint bit");
  a_write_restart: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h0 |=> !settled_ch0 ##1 !settled_ch0)
    else $error("settled held across code write");
  a_code_follows: assert property (@(posedge clk) disable iff (rst)
    clk_en ##1 clk_en |=> code_ch1 == $past(conv_data[1]))
    else $error("macro code not registered");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
    clk_en && rd && sel == 2'h3 |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // ----------------------------------------
  // Drive and conversion enables
  // ----------------------------------------
  a_ch1_drive_on: assert property (@(posedge clk) disable iff (rst)
    clk_en && converter_control.out_enable_ch1 |=> analog_out_pin_1_oe && convert_en_ch1)
    else $error("channel 1 not enabled by its bit");
  a_ch1_drive_off: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.out_enable_ch1 |=> !analog_out_pin_1_oe)
    else $error("channel 1 driven with bit clear");
  a_ch0_drive_on: assert property (@(posedge clk) disable iff (rst)
    clk_en && converter_control.out_enable_ch0 |=> analog_out_pin_0_oe && convert_en_ch0)
    else $error("channel 0 not enabled by its bit");
  a_ch0_drive_off: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.out_enable_ch0 |=> !analog_out_pin_0_oe)
    else $error("channel 0 driven with bit clear");
  a_ch0_indep_conv: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.joint_convert_enable
    |=> convert_en_ch0 == $past(converter_control.out_enable_ch0))
    else $error("channel 0 conversion not independent");
  a_ch1_indep_conv: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.joint_convert_enable
    |=> convert_en_ch1 == $past(converter_control.out_enable_ch1))
    else $error("channel 1 conversion not independent");
  a_conv_all_off: assert property (@(posedge clk) disable iff (rst)
    clk_en && !(|chan_oe) |=> !convert_en_ch0 && !convert_en_ch1)
    else $error("conversion with both enables clear");
  // Power must drop when nothing asks for it
  a_power_idle: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.joint_convert_enable && !(|chan_oe) |=> !analog_power_en)
    else $error("analog power kept with nothing enabled");
  a_drive_clear: assert property (@(posedge clk) disable iff (rst)
    clk_en && !converter_control.out_enable_ch0 |=> !settled_ch0 && !analog_out_pin_0_oe)
    else $error("channel 0 still driving after clear");

  // ----------------------------------------
  // Register contents
  // ----------------------------------------
  a_ch0_code_store: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h0 && !standby |=> conv_data[0] == $past(wdata))
    else $error("channel 0 code not stored");
  a_ch1_code_store: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h1 && !standby |=> conv_data[1] == $past(wdata))
    else $error("channel 1 code not stored");
  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h2 && !standby |=> converter_control[7:5] == $past(wdata[7:5]))
    else $error("control enables not stored");
  a_standby_wins: assert property (@(posedge clk) disable iff (rst)
    clk_en && standby && wr |=> conv_data[0] == 8'h00 && conv_data[1] == 8'h00)
    else $error("write beat standby");
  a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h3 && !standby
    |=> $stable(converter_control) && $stable(conv_data[0]) && $stable(conv_data[1]))
    else $error("unmapped write changed a register");

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  a_rdata_ch0: assert property (@(posedge clk) disable iff (rst)
    clk_en && rd && sel == 2'h0 |=> rdata == $past(conv_data[0]))
    else $error("channel 0 read wrong");
  a_rdata_ch1: assert property (@(posedge clk) disable iff (rst)
    clk_en && rd && sel == 2'h1 |=> rdata == $past(conv_data[1]))
    else $error("channel 1 read wrong");
  a_rdata_ctrl: assert property (@(posedge clk) disable iff (rst)
    clk_en && rd && sel == 2'h2 |=> rdata[4:0] == 5'h1f)
    else $error("control low bits not read as one");
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !(clk_en && rd) |=> $stable(rdata))
    else $error("read data moved without a read");

  // ----------------------------------------
  // Macro interface and settling
  // ----------------------------------------
  a_code_ch0_reg: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> code_ch0 == $past(conv_data[0]))
    else $error("channel 0 macro code not registered");
  // A frozen clock must not let the macro see a half-updated code
  a_macro_freeze: assert property (@(posedge clk) disable iff (rst)
    !clk_en |=> $stable(code_ch0) && $stable(convert_en_ch0) && $stable(code_ch1))
    else $error("macro outputs moved while frozen");
  a_ch1_restart: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr && sel == 2'h1 |=> !settled_ch1)
    else $error("channel 1 settled held across write");
  a_ch0_settle_on: assert property (@(posedge clk) disable iff (rst)
    settled_ch0 |-> convert_en_ch0 && analog_out_pin_0_oe)
    else $error("channel 0 settled while off");
  a_ch1_settle_on: assert property (@(posedge clk) disable iff (rst)
    settled_ch1 |-> convert_en_ch1 && analog_out_pin_1_oe)
    else $error("channel 1 settled while off");
  a_count_bound: assert property (@(posedge clk) disable iff (rst)
    gen_chan[0].settle_cnt <= CONV_CYCLES)
    else $error("settle counter past its end");

  c_ch0_settles: cover property (@(posedge clk) disable iff (rst) $rose(settled_ch0));
  c_joint_mode: cover property (@(posedge clk) disable iff (rst)
    convert_en_ch1 && !analog_out_pin_1_oe);
  c_standby: cover property (@(posedge clk) disable iff (rst) standby && clk_en);
  c_ctrl_read: cover property (@(posedge clk) disable iff (rst) rd && sel == 2'h2);
  c_ch1_restart: cover property (@(posedge clk) disable iff (rst) settled_ch1 ##1 !settled_ch1);

endmodule : dacc_control
`default_nettype wire

// >>> verif/test_dacc_control.sv
// Self-checking bench for the two-channel converter control block
`timescale 1ns/1ps
`default_nettype none
`include "dacc_defs.svh"
module test_dacc_control;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int CONV = 4;
  localparam int LIMIT = 3000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic standby = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, code_ch0, code_ch1;
  logic conv0, conv1, oe0, oe1, set0, set1, pw;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [7:0] v;
  logic [4:0] e;
  dacc_control #(.CONV_CYCLES(CONV)) i_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .standby(standby),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .code_ch0(code_ch0),
    .convert_en_ch0(conv0), .analog_out_pin_0_oe(oe0), .settled_ch0(set0), .code_ch1(code_ch1),
    .convert_en_ch1(conv1), .analog_out_pin_1_oe(oe1), .settled_ch1(set1), .analog_power_en(pw));
  always #10 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data first stands in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg
  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`DACC_OFS_DATA_CH0, 8'h00);
    rd_reg(`DACC_OFS_DATA_CH1, 8'h00);
    rd_reg(`DACC_OFS_CONTROL, 8'h1f);
    chk({1'b0, conv0, conv1, oe0, oe1, set0, set1, pw}, 8'h00);
    wr_reg(`DACC_OFS_DATA_CH0, 8'ha5);
    wr_reg(`DACC_OFS_DATA_CH1, 8'h3c);
    rd_reg(`DACC_OFS_DATA_CH0, 8'ha5);
    rd_reg(`DACC_OFS_DATA_CH1, 8'h3c);
    chk(code_ch0, 8'ha5);
    chk(code_ch1, 8'h3c);
    // Frozen clock enable drops the write
    clk_en <= 1'b0;
    wr_reg(`DACC_OFS_DATA_CH1, 8'h11);
    clk_en <= 1'b1;
    rd_reg(`DACC_OFS_DATA_CH1, 8'h3c);
    // Every enable combination; reserved bits written as zero
    for (int k = 0; k < 8; k++)
    begin
      v = {k[2:0], 5'h00};
      wr_reg(`DACC_OFS_CONTROL, v);
      @(posedge clk);
      #1;
      e = {v[6] | (v[5] & v[7]), v[7] | (v[5] & v[6]), v[6], v[7], v[5] | v[6] | v[7]};
      chk({3'h0, conv0, conv1, oe0, oe1, pw}, {3'h0, e});
      rd_reg(`DACC_OFS_CONTROL, {v[7:5], 5'h1f});
    end
    // Channel 0 alone: settles within the delay, a write restarts it
    wr_reg(`DACC_OFS_CONTROL, 8'h40);
    wr_reg(`DACC_OFS_DATA_CH0, 8'h77);
    @(posedge clk);
    #1;
    chk({7'h00, set0}, 8'h00);
    n = 0;
    while (set0 !== 1'b1 && n < CONV + 6)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, set0}, 8'h01);
    chk({6'h00, oe1, set1}, 8'h00);
    wr_reg(`DACC_OFS_DATA_CH0, 8'hff);
    @(posedge clk);
    #1;
    chk({7'h00, set0}, 8'h00);
    chk(code_ch0, 8'hff);
    wr_reg(`DACC_OFS_CONTROL, 8'h00);
    @(posedge clk);
    #1;
    chk({6'h00, oe0, set0}, 8'h00);
    // Unmapped place reads zero and keeps nothing
    wr_reg(16'hfffb, 8'hff);
    rd_reg(16'hfffb, 8'h00);
    // Standby entry clears both codes and the three enable bits; conversion, drive and power enables all drop
    wr_reg(`DACC_OFS_CONTROL, 8'he0);
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    rd_reg(`DACC_OFS_DATA_CH0, 8'h00);
    rd_reg(`DACC_OFS_DATA_CH1, 8'h00);
    rd_reg(`DACC_OFS_CONTROL, 8'h1f);
    @(posedge clk);
    #1;
    chk({3'h0, conv0, conv1, oe0, oe1, pw}, 8'h00);
    report_and_stop();
  end
endmodule : test_dacc_control
`default_nettype wire
